// >>> src/prs_cfg.svh
// Constants of the power rail sequencer: timing, register map, fields and reset values.
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH
`define PRS_CLK_HZ 100000000
`define PRS_MS_CYC (`PRS_CLK_HZ / 1000)
`define PRS_TICK_W 17
`define PRS_DLY_MAX_MS 4'hA
`define PRS_TO_MS 13'h1388
`define PRS_LONG_MS 13'h1F40
`define PRS_RHOLD_MS 13'h03E8
`define PRS_TMR_MAX 13'h1FFF
`define PRS_DEGL_MS 6'h32
`define PRS_PGMON_MS 3'h5
`define PRS_STB_FIRST 4'h1
`define PRS_STB_LAST 4'h7
`define PRS_STB_A 4'hE
`define PRS_STB_B 4'hF
`define PRS_W_CTRL 3'h0
`define PRS_W_STAT 3'h1
`define PRS_W_EN 3'h2
`define PRS_W_SEQ 3'h3
`define PRS_W_DLY 3'h4
`define PRS_W_PGC 3'h5
`define PRS_C_UP 0
`define PRS_C_DN 1
`define PRS_C_INST 2
`define PRS_C_OFF 3
`define PRS_S_PBI 4
`define PRS_P_M1 8
`define PRS_P_M2 9
`define PRS_P_SW1 10
`define PRS_P_SW2 11
`define PRS_CTRL_RST 4'h0
`define PRS_SEQ_RST 28'h32154FE
`define PRS_DLYC_RST 24'h222222
`define PRS_PGC_RST 12'h314
`define PRS_REG_RAILS 7'h03
`endif

// >>> src/prs_pkg.sv
// Types of the power rail sequencer.
`include "prs_cfg.svh"
package prs_pkg;
   typedef enum logic [2:0] {
      PRS_OFF = 3'b000,
      PRS_WAIT = 3'b001,
      PRS_UP = 3'b010,
      PRS_ACT = 3'b011,
      PRS_DOWN = 3'b100,
      PRS_SLEEP = 3'b101,
      PRS_RHOLD = 3'b110
   } prs_state_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [4:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } prs_wb_req_t;
   typedef struct packed {
      prs_state_t state;
      logic [6:0] s1, s2, pg1, pg2;
      logic usb_p, ac_p, pbst, push_button_irq_flag;
      logic [5:0] pbcnt;
      logic [12:0] lpcnt, tmr;
      logic [`PRS_TICK_W-1:0] tick;
      logic [3:0] dly, idx, spcnt, ctrl;
      logic spec, dn_all, dn_rst, dn_ret;
      logic [6:0] en;
      logic [27:0] seq;
      logic [23:0] dlyc;
      logic [11:0] pgc;
      logic [20:0] age;
      logic [7:0] pgd;
      logic pgrun, pg_ok, mpg, rpg, woe, ack;
      logic [31:0] dat;
   } prs_st_t;
endpackage

// >>> src/prs_top.sv
// Power rail sequencer with wake, power-good and push-button logic behind a Wishbone slave.
`timescale 1ns/10ps
`include "prs_cfg.svh"
module prs_top #(
   parameter int MS_CYC = `PRS_MS_CYC
) (
   input wire logic CLOCK_I, // System clock.
   input wire logic RST_N_I, // Synchronous reset, active low.
   input prs_pkg::prs_wb_req_t WB_REQ_I, // Wishbone request group.
   output logic WB_ACK_O, // Wishbone acknowledge.
   output logic [31:0] WB_DAT_O, // Wishbone read data.
   input wire logic POWER_ENABLE_PIN_I, // Host power enable level.
   input wire logic PUSH_BUTTON_INPUT_N_I, // Push button, low when pressed.
   input wire logic USB_PRESENT_I, // USB supply present.
   input wire logic AC_PRESENT_I, // Adapter supply present.
   input wire logic HARD_RESET_PIN_N_I, // Hard reset pin, active low.
   input wire logic UVLO_I, // Undervoltage lockout.
   input wire logic OVER_TEMP_SHUTDOWN_I, // Over-temperature shutdown.
   input wire logic [6:0] RAIL_PG_I, // Deglitched per-rail power good.
   output logic [6:0] RAIL_EN_O, // Rail enables.
   output logic WAKE_OUTPUT_N_O, // Wake pin drive level.
   output logic WAKE_OUTPUT_OE_O, // Wake pin pulled low while high.
   output logic MAIN_POWER_GOOD_O, // Main power good.
   output logic REGULATOR_POWER_GOOD_O // Always-on regulator power good.
);
   import prs_pkg::*;

   // ---------------------------------------------------------------
   // Parameter check and per-rail decode
   // ---------------------------------------------------------------
   if (MS_CYC < 1 || MS_CYC >= (1 << `PRS_TICK_W))
   begin : g_bad_ms
      $error("MS_CYC does not fit the tick counter");
   end

   localparam logic [`PRS_TICK_W-1:0] TICK_LAST = `PRS_TICK_W'(MS_CYC - 1);

   prs_st_t q, d;
   logic ms, flt, take, rreq, wake, ok_sup, pb_fall, long_p;
   logic [6:0] m_idx, m0, m14, m15, mon, ign, mset;
   logic [20:0] age_v;
   logic [31:0] rdat, wv;

   assign ms = (q.tick == TICK_LAST);

   for (genvar i = 0; i < 7; i++)
   begin : g_rail
      logic [3:0] code;
      logic [2:0] age;
      assign code = q.seq[4*i +: 4];
      assign age = q.age[3*i +: 3];
      assign m_idx[i] = (code == q.idx) && (code != 4'h0);
      assign m0[i] = (code == 4'h0);
      assign m14[i] = (code == `PRS_STB_A) && (i < 2);
      assign m15[i] = (code == `PRS_STB_B) && (i < 2);
      assign mon[i] = (age == `PRS_PGMON_MS);
      assign age_v[3*i +: 3] = !q.en[i] ? 3'h0 : (ms && !mon[i]) ? age + 3'h1 : age;
   end

   // Switch rails used as plain load switches have no regulation to watch.
   assign ign = {3'b000, ~q.pgc[`PRS_P_SW2], ~q.pgc[`PRS_P_SW1], 2'b00};
   assign mset = {3'b111, q.pgc[`PRS_P_SW2], q.pgc[`PRS_P_SW1],
                  ~q.pgc[`PRS_P_M2], ~q.pgc[`PRS_P_M1]};
   assign flt = (|(q.en & mon & ~q.pg2 & ~ign)) | q.s2[5] | q.s2[6];
   assign take = WB_REQ_I.cyc && WB_REQ_I.stb && !q.ack;
   assign ok_sup = !q.s2[5] && !q.s2[6];

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [3:0] dms(input logic [3:0] c);
      return (c > 4'h9) ? `PRS_DLY_MAX_MS : c + 4'h1;
   endfunction

   function automatic logic [3:0] dsel(input logic [23:0] v, input logic [3:0] k);
      return v[4*k +: 4];
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (o & ~m) | (n & m);
   endfunction

   function automatic prs_st_t go_down(input prs_st_t s, input logic all,
                                       input logic rst, input logic ret);
      s.state = PRS_DOWN;
      s.idx = `PRS_STB_LAST;
      s.dly = 4'h0;
      s.dn_all = all | rst;
      s.dn_rst = rst;
      s.dn_ret = ret;
      // A pending second always-on strobe must not turn a rail back on during the way down.
      s.spec = 1'b0;
      // A reset drops the unsequenced rails at once, not after the sequence.
      if (rst)
         s.en = s.en & ~m0;
      return s;
   endfunction

   function automatic prs_st_t go_up(input prs_st_t s);
      s.state = PRS_UP;
      s.idx = `PRS_STB_FIRST;
      s.dly = 4'h0;
      return s;
   endfunction

   function automatic prs_st_t go_wait(input prs_st_t s);
      s.state = PRS_WAIT;
      s.en = s.en | m14;
      s.spec = 1'b1;
      s.spcnt = dms(dsel(s.dlyc, 4'h5));
      return s;
   endfunction

   // ---------------------------------------------------------------
   // Register read mux
   // ---------------------------------------------------------------
   always_comb
   begin
      unique case (WB_REQ_I.adr[4:2])
         `PRS_W_CTRL: rdat = {28'h0, q.ctrl};
         `PRS_W_STAT: rdat = {25'h0, q.rpg, q.mpg, q.push_button_irq_flag, q.pbst, q.state};
         `PRS_W_EN: rdat = {25'h0, q.en};
         `PRS_W_SEQ: rdat = {4'h0, q.seq};
         `PRS_W_DLY: rdat = {8'h0, q.dlyc};
         `PRS_W_PGC: rdat = {20'h0, q.pgc};
         default: rdat = 32'h0;
      endcase
      wv = merge(rdat, WB_REQ_I.dat, WB_REQ_I.sel);
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      d = q;
      pb_fall = 1'b0;
      long_p = 1'b0;
      d.s1 = {OVER_TEMP_SHUTDOWN_I, UVLO_I, HARD_RESET_PIN_N_I, AC_PRESENT_I,
              USB_PRESENT_I, PUSH_BUTTON_INPUT_N_I, POWER_ENABLE_PIN_I};
      d.s2 = q.s1;
      d.pg1 = RAIL_PG_I;
      d.pg2 = q.pg1;
      d.usb_p = q.s2[2];
      d.ac_p = q.s2[3];
      d.tick = ms ? '0 : q.tick + 1'b1;
      d.age = age_v;

      // Bus access; the edge logic below runs later so a new edge beats a clear.
      d.ack = take;
      if (take)
      begin
         d.dat = rdat;
         if (WB_REQ_I.we)
         begin
            unique case (WB_REQ_I.adr[4:2])
               `PRS_W_CTRL: d.ctrl = wv[3:0];
               `PRS_W_STAT: d.push_button_irq_flag = q.push_button_irq_flag & ~(WB_REQ_I.sel[0] & WB_REQ_I.dat[`PRS_S_PBI]);
               `PRS_W_EN:
               begin
                  if (q.state != PRS_UP && q.state != PRS_DOWN)
                     d.en = wv[6:0];
               end
               `PRS_W_SEQ: d.seq = wv[27:0];
               `PRS_W_DLY: d.dlyc = wv[23:0];
               `PRS_W_PGC: d.pgc = wv[11:0];
               default: d.dat = 32'h0;
            endcase
         end
      end

      // Push-button deglitch, edge flag and long press.
      if (q.s2[1] == q.pbst)
         d.pbcnt = 6'h0;
      else if (q.pbcnt == `PRS_DEGL_MS)
      begin
         d.pbst = q.s2[1];
         d.pbcnt = 6'h0;
         d.push_button_irq_flag = 1'b1;
         pb_fall = !q.s2[1];
      end
      else if (ms)
         d.pbcnt = q.pbcnt + 6'h1;
      // Holding the button keeps firing every long interval, cycling power.
      if (q.pbst)
         d.lpcnt = 13'h0;
      else if (q.lpcnt == `PRS_LONG_MS)
      begin
         d.lpcnt = 13'h0;
         long_p = 1'b1;
      end
      else if (ms)
         d.lpcnt = q.lpcnt + 13'h1;

      wake = pb_fall | (q.s2[2] & !q.usb_p) | (q.s2[3] & !q.ac_p);
      rreq = !q.s2[4] | long_p;

      // Second always-on strobe after the sixth delay.
      if (q.spec && q.spcnt == 4'h0)
      begin
         d.en = d.en | m15;
         d.spec = 1'b0;
      end
      else if (q.spec && ms)
         d.spcnt = q.spcnt - 4'h1;

      // Power-good delay after the sequencer is done.
      if (q.pgrun)
      begin
         if (q.pgd == q.pgc[7:0])
         begin
            d.pg_ok = 1'b1;
            d.pgrun = 1'b0;
         end
         else if (ms)
            d.pgd = q.pgd + 8'h1;
      end

      unique case (q.state)
         PRS_OFF:
         begin
            if (wake && ok_sup)
               d = go_wait(d);
         end
         PRS_WAIT:
         begin
            if (q.s2[0])
               d = go_up(d);
            else if (q.tmr >= `PRS_TO_MS)
               d = go_down(d, q.ctrl[`PRS_C_OFF], 1'b0, 1'b0);
         end
         PRS_UP:
         begin
            if (q.dly != 4'h0)
            begin
               if (ms)
                  d.dly = q.dly - 4'h1;
            end
            else
            begin
               d.en = d.en | m_idx;
               if (q.idx == `PRS_STB_LAST)
               begin
                  d.state = PRS_ACT;
                  d.ctrl[`PRS_C_UP] = 1'b0;
                  d.pgrun = 1'b1;
                  d.pgd = 8'h0;
               end
               else
               begin
                  d.dly = dms(dsel(q.dlyc, q.idx - 4'h1));
                  d.idx = q.idx + 4'h1;
               end
            end
         end
         PRS_ACT:
         begin
            if (!q.s2[0])
               d = go_down(d, q.ctrl[`PRS_C_OFF], 1'b0, 1'b0);
            else if (q.ctrl[`PRS_C_DN])
               d = go_down(d, 1'b0, 1'b0, 1'b1);
            else if (q.ctrl[`PRS_C_UP])
               d = go_up(d);
         end
         PRS_DOWN:
         begin
            if (q.dly != 4'h0 && !q.ctrl[`PRS_C_INST])
            begin
               if (ms)
                  d.dly = q.dly - 4'h1;
            end
            else
            begin
               d.en = d.en & ~m_idx;
               d.dly = 4'h0;
               if (q.idx == `PRS_STB_A || (q.idx == `PRS_STB_FIRST && !q.dn_all))
               begin
                  if (q.dn_ret)
                  begin
                     d.state = PRS_ACT;
                     d.ctrl[`PRS_C_DN] = 1'b0;
                  end
                  else if (q.dn_rst)
                     d.state = PRS_RHOLD;
                  else if (q.dn_all)
                  begin
                     d.en = d.en & ~m0;
                     d.state = PRS_OFF;
                  end
                  else
                     d.state = PRS_SLEEP;
               end
               else if (q.idx == `PRS_STB_FIRST)
                  d.idx = `PRS_STB_B;
               else if (q.idx == `PRS_STB_B)
               begin
                  d.idx = `PRS_STB_A;
                  d.dly = dms(dsel(q.dlyc, 4'h5));
               end
               else
               begin
                  d.idx = q.idx - 4'h1;
                  d.dly = dms(dsel(q.dlyc, q.idx - 4'h2));
               end
            end
         end
         PRS_SLEEP:
         begin
            if (q.s2[0])
               d = go_up(d);
            else if (wake && ok_sup)
               d = go_wait(d);
         end
         PRS_RHOLD:
         begin
            if (q.tmr >= `PRS_RHOLD_MS && q.s2[4])
               d = go_wait(d);
         end
         default: d.state = PRS_OFF;
      endcase

      // Reset requests and faults override the normal flow.
      if (q.state == PRS_WAIT || q.state == PRS_UP || q.state == PRS_ACT ||
          q.state == PRS_SLEEP)
      begin
         if (rreq)
            d = go_down(d, 1'b1, 1'b1, 1'b0);
         else if (flt)
            d = go_down(d, 1'b1, 1'b0, 1'b0);
      end

      if (d.state != q.state)
         d.tmr = 13'h0;
      else if (ms && q.tmr != `PRS_TMR_MAX)
         d.tmr = q.tmr + 13'h1;

      if (d.state != q.state &&
          (d.state == PRS_OFF || d.state == PRS_SLEEP || d.state == PRS_RHOLD))
      begin
         d.ctrl = `PRS_CTRL_RST;
         d.seq = `PRS_SEQ_RST;
         d.dlyc = `PRS_DLYC_RST;
         d.pgc = `PRS_PGC_RST;
      end

      if (d.en == 7'h0 || flt)
      begin
         d.pg_ok = 1'b0;
         d.pgrun = 1'b0;
      end
      // A stale good flag from sleep must wait for the new delay to run out.
      d.mpg = d.pg_ok && !d.pgrun && d.state == PRS_ACT &&
              !(|(d.en & mset & mon & ~q.pg2));
      d.rpg = d.pg_ok && (|(d.en & `PRS_REG_RAILS)) &&
              !(|(d.en & `PRS_REG_RAILS & mon & ~q.pg2));
      d.woe = (d.state == PRS_WAIT);
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (!RST_N_I)
      begin
         q <= '0;
         q.state <= PRS_OFF;
         q.s1 <= 7'h12;
         q.s2 <= 7'h12;
         q.pbst <= 1'b1;
         q.ctrl <= `PRS_CTRL_RST;
         q.seq <= `PRS_SEQ_RST;
         q.dlyc <= `PRS_DLYC_RST;
         q.pgc <= `PRS_PGC_RST;
      end
      else
         q <= d;
   end

   assign WB_ACK_O = q.ack;
   assign WB_DAT_O = q.dat;
   assign RAIL_EN_O = q.en;
   assign WAKE_OUTPUT_N_O = 1'b0;
   assign WAKE_OUTPUT_OE_O = q.woe;
   assign MAIN_POWER_GOOD_O = q.mpg;
   assign REGULATOR_POWER_GOOD_O = q.rpg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_pb_edge;
      !$stable(q.pbst);
   endsequence
   sequence s_up_last;
      q.state == PRS_UP && q.dly == 4'h0 && q.idx == `PRS_STB_LAST && !flt && !rreq;
   endsequence

   property p_up_fire;
      (q.state == PRS_UP && q.dly == 4'h0 && !flt && !rreq) |=>
         ((q.en & $past(m_idx)) == $past(m_idx));
   endproperty
   a_up_fire: assert property (p_up_fire) else $error("strobe rails not enabled");
   property p_up_done;
      s_up_last |=> q.state == PRS_ACT && !q.ctrl[`PRS_C_UP] ##1 q.pgrun || q.pg_ok;
   endproperty
   a_up_done: assert property (p_up_done) else $error("up bit not cleared");
   property p_en_lock;
      (take && WB_REQ_I.we && WB_REQ_I.adr[4:2] == `PRS_W_EN && q.state == PRS_UP &&
       q.dly > 4'h1 && !flt && !rreq) |=> $stable(q.en);
   endproperty
   a_en_lock: assert property (p_en_lock) else $error("enable written while busy");
   property p_inst;
      (q.state == PRS_DOWN && q.ctrl[`PRS_C_INST] && q.idx > 4'h1 &&
       q.idx <= `PRS_STB_LAST) |=> q.idx == $past(q.idx) - 4'h1;
   endproperty
   a_inst: assert property (p_inst) else $error("instant down waited");
   property p_fault;
      (q.state == PRS_ACT && flt && !rreq) |=> q.state == PRS_DOWN && q.dn_all;
   endproperty
   a_fault: assert property (p_fault) else $error("fault did not shut down");
   property p_wake_act;
      q.state == PRS_ACT |-> !WAKE_OUTPUT_OE_O;
   endproperty
   a_wake_act: assert property (p_wake_act) else $error("wake low in active");
   property p_pg_off;
      q.en == 7'h0 |-> !MAIN_POWER_GOOD_O && !REGULATOR_POWER_GOOD_O;
   endproperty
   a_pg_off: assert property (p_pg_off) else $error("power good with rails off");
   property p_pbi;
      s_pb_edge |-> q.push_button_irq_flag;
   endproperty
   a_pbi: assert property (p_pbi) else $error("button edge not flagged");
   property p_wait_to;
      q.state == PRS_WAIT |-> q.tmr <= `PRS_TO_MS;
   endproperty
   a_wait_to: assert property (p_wait_to) else $error("enable timeout overrun");
endmodule

// >>> verification/prs_host_model.sv
// Host processor model that answers hold_i with the power enable level, lagging by lag_i cycles.
`timescale 1ns/10ps
module prs_host_model (
   input wire logic clk_i, // System clock.
   input wire logic rst_n_i, // Synchronous reset, active low.
   input wire logic hold_i, // Host wants the rails up.
   input wire logic [15:0] lag_i, // Cycles before the host answers.
   output logic power_enable_pin_o // Power enable level.
);
   // ---------------------------------------------------------------
   // Enable answer
   // ---------------------------------------------------------------
   logic [15:0] wait_q;
   // A lag beyond the five second limit would model a host that hangs.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || !hold_i)
      begin
         wait_q <= 16'h0000;
         power_enable_pin_o <= 1'b0;
      end
      else if (wait_q < lag_i)
         wait_q <= wait_q + 16'h0001;
      else
         power_enable_pin_o <= 1'b1;
   end
endmodule

// >>> verification/power_rail_sequencer_tb.sv
// Self-checking bench for the power rail sequencer.
`timescale 1ns/10ps
`include "prs_cfg.svh"
`define TB_CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("Error %s expected %h seen %h", what, exp, got); end end
module power_rail_sequencer_tb;
   import prs_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   prs_wb_req_t wb_req = '0;
   logic wb_ack;
   logic [31:0] wb_dat;
   logic pb_n = 1'b1;
   logic usb = 1'b0;
   logic ac = 1'b0;
   logic hard_rst_n = 1'b1;
   logic [6:0] rail_pg = 7'h3F;
   logic [6:0] rail_en;
   logic wake_oe;
   logic mpg;
   logic rpg;
   logic power_enable_pin;
   logic host_hold = 1'b0;
   logic [9:0] obs;
   logic [31:0] rd;
   int mismatches = 0;
   int n_checks = 0;
   int cnt;
   assign obs = {rpg, mpg, wake_oe, rail_en};
   always #5 clk = ~clk;
   prs_top #(.MS_CYC(10)) dut_u (.CLOCK_I(clk), .RST_N_I(rst_n), .WB_REQ_I(wb_req),
      .WB_ACK_O(wb_ack), .WB_DAT_O(wb_dat), .POWER_ENABLE_PIN_I(power_enable_pin),
      .PUSH_BUTTON_INPUT_N_I(pb_n), .USB_PRESENT_I(usb), .AC_PRESENT_I(ac),
      .HARD_RESET_PIN_N_I(hard_rst_n), .UVLO_I(1'b0), .OVER_TEMP_SHUTDOWN_I(1'b0),
      .RAIL_PG_I(rail_pg), .RAIL_EN_O(rail_en), .WAKE_OUTPUT_N_O(),
      .WAKE_OUTPUT_OE_O(wake_oe), .MAIN_POWER_GOOD_O(mpg), .REGULATOR_POWER_GOOD_O(rpg));
   prs_host_model host_u (.clk_i(clk), .rst_n_i(rst_n), .hold_i(host_hold),
      .lag_i(16'h0040), .power_enable_pin_o(power_enable_pin));
   // ---------------------------------------------------------------
   // Bus and wait tasks
   // ---------------------------------------------------------------
   task stop_test;
      $display("Checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Every call starts just after a rising edge and ends one idle cycle later.
   task automatic wb_xfer(input logic we, input logic [2:0] word, input logic [31:0] wdat,
      output logic [31:0] rdat);
      int n;
      n = 0;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {word, 2'b00}, sel: 4'hF, dat: wdat};
      @(posedge clk);
      while (wb_ack !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      rdat = wb_dat;
      wb_req <= '0;
      @(posedge clk);
      if (n >= 20)
      begin
         `TB_CHK("bus ack", 1'b1, wb_ack)
         stop_test();
      end
   endtask
   task automatic wait_obs(input logic [9:0] mask, input logic [9:0] val, output int cyc);
      cyc = 0;
      while ((obs & mask) !== val && cyc < 20000)
      begin
         @(posedge clk);
         cyc++;
      end
      `TB_CHK("observed pins", val, obs & mask)
      if (cyc >= 20000)
         stop_test();
   endtask
   task automatic wait_state(input logic [2:0] st);
      int n;
      n = 0;
      do
      begin
         wb_xfer(1'b0, `PRS_W_STAT, '0, rd);
         n++;
      end
      while (rd[2:0] !== st && n < 3000);
      `TB_CHK("state", st, rd[2:0])
      if (n >= 3000)
         stop_test();
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      `TB_CHK("rails at reset", 7'h00, rail_en)
      `TB_CHK("main pg at reset", 1'b0, mpg)
      wb_xfer(1'b0, `PRS_W_SEQ, '0, rd);
      `TB_CHK("strobe codes", {4'h0, `PRS_SEQ_RST}, rd)
      wb_xfer(1'b0, `PRS_W_DLY, '0, rd);
      `TB_CHK("delay codes", {8'h00, `PRS_DLYC_RST}, rd)
      wb_xfer(1'b0, `PRS_W_PGC, '0, rd);
      `TB_CHK("pg config", `PRS_PGC_RST, rd[11:0])
      wb_xfer(1'b1, 3'h6, 32'hFFFFFFFF, rd);
      wb_xfer(1'b0, 3'h6, '0, rd);
      `TB_CHK("unmapped word", 32'h00000000, rd)
      // A supply rise wakes from off; rail 6 reports good only after it starts up.
      usb <= 1'b1;
      wait_obs(10'h081, 10'h081, cnt);
      host_hold <= 1'b1;
      wait_obs(10'h010, 10'h010, cnt);
      `TB_CHK("wake released", 1'b0, wake_oe)
      `TB_CHK("second regulator", 1'b1, rail_en[1])
      wait_obs(10'h020, 10'h020, cnt);
      `TB_CHK("first delay", 1'b1, (cnt >= 20 && cnt <= 31))
      wait_obs(10'h040, 10'h040, cnt);
      `TB_CHK("strobe order", 1'b0, rail_en[2])
      repeat (20) @(posedge clk);
      rail_pg <= 7'h7F;
      wait_obs(10'h008, 10'h008, cnt);
      wait_obs(10'h100, 10'h100, cnt);
      `TB_CHK("pg delay", 1'b1, (cnt >= 220 && cnt <= 270))
      `TB_CHK("regulator pg", 1'b1, rpg)
      wait_state(3'h3);
      // Software power-up: rail enables must refuse writes while it runs.
      wb_xfer(1'b1, `PRS_W_CTRL, 32'h00000001, rd);
      wb_xfer(1'b1, `PRS_W_EN, 32'h00000000, rd);
      wb_xfer(1'b0, `PRS_W_EN, '0, rd);
      `TB_CHK("enables while running", 7'h7F, rd[6:0])
      wait_state(3'h3);
      wb_xfer(1'b0, `PRS_W_CTRL, '0, rd);
      `TB_CHK("up bit cleared", 1'b0, rd[`PRS_C_UP])
      // Software power-down with switch 1 taken out of the sequence.
      wb_xfer(1'b1, `PRS_W_SEQ, {4'h0, `PRS_SEQ_RST & 28'hFFFF0FF}, rd);
      wb_xfer(1'b1, `PRS_W_CTRL, 32'h00000002, rd);
      wait_obs(10'h040, 10'h000, cnt);
      `TB_CHK("reverse order", 1'b1, rail_en[4])
      wait_obs(10'h010, 10'h000, cnt);
      wait_state(3'h3);
      wb_xfer(1'b0, `PRS_W_EN, '0, rd);
      `TB_CHK("enables after down", 7'h07, rd[6:0])
      // Enable low with the off bit clear leads to sleep; enable high alone wakes.
      host_hold <= 1'b0;
      wait_state(3'h5);
      `TB_CHK("rails in sleep", 7'h07, rail_en)
      `TB_CHK("main pg in sleep", 1'b0, mpg)
      `TB_CHK("regulator pg in sleep", 1'b1, rpg)
      wb_xfer(1'b0, `PRS_W_SEQ, '0, rd);
      `TB_CHK("codes after sleep", {4'h0, `PRS_SEQ_RST}, rd)
      host_hold <= 1'b1;
      wait_state(3'h3);
      `TB_CHK("main pg before delay", 1'b0, mpg)
      wait_obs(10'h07F, 10'h07F, cnt);
      // Instant power-down to off.
      wb_xfer(1'b1, `PRS_W_CTRL, 32'h0000000C, rd);
      host_hold <= 1'b0;
      wait_obs(10'h07C, 10'h000, cnt);
      `TB_CHK("instant down", 1'b1, (cnt < 20))
      wait_obs(10'h07F, 10'h000, cnt);
      wait_state(3'h0);
      `TB_CHK("pg outputs off", 2'b00, {mpg, rpg})
      wb_xfer(1'b0, `PRS_W_CTRL, '0, rd);
      `TB_CHK("control after off", 4'h0, rd[3:0])
      // Button wake after the deglitch time, then a rail fault.
      pb_n <= 1'b0;
      repeat (300) @(posedge clk);
      `TB_CHK("wake before deglitch", 1'b0, wake_oe)
      wait_obs(10'h080, 10'h080, cnt);
      pb_n <= 1'b1;
      wb_xfer(1'b0, `PRS_W_STAT, '0, rd);
      `TB_CHK("button flag", 1'b1, rd[`PRS_S_PBI])
      host_hold <= 1'b1;
      wait_state(3'h3);
      rail_pg <= 7'h5F;
      wait_obs(10'h07F, 10'h000, cnt);
      wait_state(3'h0);
      `TB_CHK("main pg after fault", 1'b0, mpg)
      // Adapter wake with enable low, then the reset pin while waiting for enable.
      host_hold <= 1'b0;
      ac <= 1'b1;
      wait_obs(10'h081, 10'h081, cnt);
      hard_rst_n <= 1'b0;
      wait_state(3'h6);
      `TB_CHK("rails in reset hold", 7'h00, rail_en)
      hard_rst_n <= 1'b1;
      wait_obs(10'h080, 10'h080, cnt);
      `TB_CHK("reset hold time", 1'b1, (cnt >= 9900 && cnt <= 10000))
      // No enable follows, so the wait times out; off bit clear leads to sleep.
      repeat (49900) @(posedge clk);
      `TB_CHK("enable timeout early", 1'b1, wake_oe)
      wait_obs(10'h080, 10'h000, cnt);
      wait_state(3'h5);
      stop_test();
   end
endmodule
